// *** tcm_map.vh ***
`ifndef TCM_MAP_VH
`define TCM_MAP_VH
// Register addresses
`define TCM_ADDR_SETUP      8'h00
`define TCM_ADDR_SHUNT_CH1  8'h01
`define TCM_ADDR_BUS_CH1    8'h02
`define TCM_ADDR_SHUNT_CH2  8'h03
// Setup register fields
`define TCM_RST_BIT         15
`define TCM_EN1_BIT         14
`define TCM_EN2_BIT         13
`define TCM_EN3_BIT         12
`define TCM_AVG_HI          11
`define TCM_AVG_LO          9
`define TCM_BCT_HI          8
`define TCM_BCT_LO          6
`define TCM_SCT_HI          5
`define TCM_SCT_LO          3
`define TCM_MODE_HI         2
`define TCM_MODE_LO         0
// Reset values
`define TCM_SETUP_RESET     16'h7127
`define TCM_RESULT_RESET    16'h0000
// Conversion times in ns per code
`define TCM_CT0_NS          140000
`define TCM_CT1_NS          204000
`define TCM_CT2_NS          332000
`define TCM_CT3_NS          588000
`define TCM_CT4_NS          1100000
`define TCM_CT5_NS          2116000
`define TCM_CT6_NS          4156000
`define TCM_CT7_NS          8244000
`define TCM_CLK_NS          4
`endif

// *** tcm_averager.v ***
`timescale 1ns/1ps
`default_nettype none
// Accumulates signed samples and yields the mean as a 16-bit result word
module tcm_averager (
  // Clock and reset
  input  wire        mclk,
  input  wire        srst,
  // Control
  input  wire        clearAcc,
  input  wire [2:0]  avgCode,
  // Sample in
  input  wire        sampleValid,
  input  wire [12:0] sampleIn,
  // Mean out
  output reg         meanValid,
  output reg  [15:0] meanWord
);
  reg  [23:0] accReg;
  reg  [10:0] cntReg;
  wire [23:0] sumNow;
  wire [10:0] cntNow;
  wire [23:0] meanFull;

  // Log2 of sample count per code
  function [3:0] avgShift;
    input [2:0] code;
    begin
      case (code)
        3'h0: avgShift = 4'h0;
        3'h1: avgShift = 4'h2;
        3'h2: avgShift = 4'h4;
        3'h3: avgShift = 4'h6;
        3'h4: avgShift = 4'h7;
        3'h5: avgShift = 4'h8;
        3'h6: avgShift = 4'h9;
        default: avgShift = 4'hA;
      endcase
    end
  endfunction

  assign sumNow = accReg + {{11{sampleIn[12]}}, sampleIn};
  assign cntNow = cntReg + 11'h001;
  // Arithmetic shift keeps the sign, rounds toward minus infinity
  assign meanFull = $signed(sumNow) >>> avgShift(avgCode);

  // Accumulate and emit mean
  always @(posedge mclk) begin
    if (srst || clearAcc) begin
      accReg    <= 24'h000000;
      cntReg    <= 11'h000;
      meanValid <= 1'b0;
      meanWord  <= 16'h0000;
    end else begin
      meanValid <= 1'b0;
      if (sampleValid) begin
        if (cntNow == (11'h001 << avgShift(avgCode))) begin
          accReg    <= 24'h000000;
          cntReg    <= 11'h000;
          meanValid <= 1'b1;
          // Signed left-justified word, sign in bit 15, low three bits zero
          meanWord  <= {meanFull[12:0], 3'h0};
        end else begin
          accReg <= sumNow;
          cntReg <= cntNow;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tcm_monitor_core.v ***
// Behaviour
// RULE1 - Writing setup bit 15 resets all registers to defaults; the bit self-clears.
// RULE2 - Bits 14,13,12 enable channels one, two, three; all set after reset.
// RULE3 - Bits 11-9 pick 1,4,16,64,128,256,512,1024 averaged samples; default 0.
// RULE4 - Bits 8-6 pick bus conversion time 140us to 8.244ms; default code 4.
// RULE5 - Bits 5-3 pick shunt conversion time, same encoding; default code 4.
// RULE6 - Bits 2-0: power-down, single-shot or continuous shunt/bus/both; default 111.
// RULE7 - Results: sign bit 15, data bits 14-3, two's complement, bits 2-0 zero.
// RULE8 - Shunt result count is 40 uV; 163.8 mV reads 7FF8.
// RULE9 - Bus result count is 8 mV; 32.76 V reads 7FF8.
// RULE10 - Shunt result registers hold averaged shunt values of their channel.
// RULE11 - Result registers are read-only and read zero after reset.
// RULE12 - Setup reads are harmless; a setup write restarts conversion with new settings.
// RULE13 - Setup register is at address 00h with reset value 7127h.
// RULE14 - Enabled channels convert in ascending order, shunt then bus; single-shot idles.
`timescale 1ns/1ps
`default_nettype none
`include "tcm_map.vh"
module tcm_monitor_core (
  // Clock and reset
  input  wire        mclk,
  input  wire        srst,
  // Register access port from serial engine
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWdata,
  output reg  [15:0] regRdata,
  output reg         regRvalid,
  // Converter front end, 13-bit signed codes (40 uV or 8 mV per count)
  output reg  [1:0]  convChannel,
  output reg         convIsBus,
  output reg         convBusy,
  input  wire        convDone,
  input  wire [12:0] convData,
  // Setup fields for surrounding logic
  output reg  [15:0] setupWord
);
  // ****************************************
  // State and registers
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_NEXT = 2'h2;
  localparam [1:0] ST_HOLD = 2'h3;

  reg  [15:0] setupReg;
  reg  [15:0] shuntCh1Reg;
  reg  [15:0] busCh1Reg;
  reg  [15:0] shuntCh2Reg;
  reg  [1:0]  stateReg;
  reg  [1:0]  chanReg;
  reg         busPhaseReg;
  reg  [21:0] timerReg;
  reg  [12:0] sampleReg;
  reg         sampleValidReg;
  wire        setupWrite;
  wire        softReset;
  wire        meanValid;
  wire [15:0] meanWord;
  wire [2:0]  modeField;
  wire        doShunt;
  wire        doBus;
  wire [2:0]  chanEn;

  // Conversion time in clock cycles for a time code
  function [21:0] ctCycles;
    input [2:0] code;
    reg   [31:0] cycFull;
    begin
      case (code)
        3'h0: cycFull = `TCM_CT0_NS / `TCM_CLK_NS;
        3'h1: cycFull = `TCM_CT1_NS / `TCM_CLK_NS;
        3'h2: cycFull = `TCM_CT2_NS / `TCM_CLK_NS;
        3'h3: cycFull = `TCM_CT3_NS / `TCM_CLK_NS;
        3'h4: cycFull = `TCM_CT4_NS / `TCM_CLK_NS;
        3'h5: cycFull = `TCM_CT5_NS / `TCM_CLK_NS;
        3'h6: cycFull = `TCM_CT6_NS / `TCM_CLK_NS;
        default: cycFull = `TCM_CT7_NS / `TCM_CLK_NS;
      endcase
      // Longest count fits in 22 bits
      ctCycles = cycFull[21:0];
    end
  endfunction

  // Lowest enabled channel at or above a start index, 2'h3 when none
  function [1:0] nextChan;
    input [2:0] en;
    input [1:0] from;
    begin
      if (from == 2'h0 && en[0])
        nextChan = 2'h0;
      else if (from <= 2'h1 && en[1])
        nextChan = 2'h1;
      else if (from <= 2'h2 && en[2])
        nextChan = 2'h2;
      else
        nextChan = 2'h3;
    end
  endfunction

  assign setupWrite = regWrite && (regAddr == `TCM_ADDR_SETUP);
  // RULE1 soft reset request
  assign softReset  = setupWrite && regWdata[`TCM_RST_BIT];
  assign modeField  = setupReg[`TCM_MODE_HI:`TCM_MODE_LO];
  // RULE6 mode decode
  assign doShunt    = modeField[0];
  assign doBus      = modeField[1];
  // RULE2 channel enables, channel one at index 0
  assign chanEn     = {setupReg[`TCM_EN3_BIT], setupReg[`TCM_EN2_BIT],
                       setupReg[`TCM_EN1_BIT]};

  // ****************************************
  // Averaging engine
  // ****************************************
  // RULE3 averaging count applied to each result
  tcm_averager uAvg (
    .mclk        (mclk),
    .srst        (srst),
    .clearAcc    (setupWrite || stateReg == ST_NEXT),
    .avgCode     (setupReg[`TCM_AVG_HI:`TCM_AVG_LO]),
    .sampleValid (sampleValidReg),
    .sampleIn    (sampleReg),
    .meanValid   (meanValid),
    .meanWord    (meanWord)
  );

  // ****************************************
  // Setup register
  // ****************************************
  // RULE13 reset value and address
  always @(posedge mclk) begin
    if (srst || softReset) begin
      setupReg <= `TCM_SETUP_RESET;
    end else if (setupWrite) begin
      // RULE1 stored with reset bit clear
      setupReg <= {1'b0, regWdata[14:0]};
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // RULE14 ascending channels, shunt then bus
  always @(posedge mclk) begin
    if (srst || softReset) begin
      stateReg       <= ST_NEXT;
      chanReg        <= 2'h0;
      busPhaseReg    <= 1'b0;
      timerReg       <= 22'h000000;
      sampleReg      <= 13'h0000;
      sampleValidReg <= 1'b0;
    end else if (setupWrite) begin
      // RULE12 write halts and restarts the pass
      stateReg       <= ST_NEXT;
      chanReg        <= 2'h0;
      busPhaseReg    <= 1'b0;
      timerReg       <= 22'h000000;
      sampleValidReg <= 1'b0;
    end else begin
      sampleValidReg <= 1'b0;
      case (stateReg)
        ST_NEXT: begin
          // RULE6 power-down and empty passes go to ST_IDLE, or back to ST_NEXT when mode bit 2 is set
          if (!(doShunt || doBus) || nextChan(chanEn, chanReg) == 2'h3) begin
            stateReg <= modeField[2] ? ST_NEXT : ST_IDLE;
            chanReg  <= 2'h0;
          end else begin
            chanReg     <= nextChan(chanEn, chanReg);
            busPhaseReg <= !doShunt;
            timerReg    <= 22'h000000;
            stateReg    <= ST_CONV;
          end
        end
        ST_CONV: begin
          // RULE4 RULE5 conversion time per measurement kind
          if (timerReg >= ctCycles(busPhaseReg ?
              setupReg[`TCM_BCT_HI:`TCM_BCT_LO] :
              setupReg[`TCM_SCT_HI:`TCM_SCT_LO]) - 22'h000001 && convDone) begin
            sampleReg      <= convData;
            sampleValidReg <= 1'b1;
            timerReg       <= 22'h000000;
            stateReg       <= ST_HOLD;
          end else begin
            timerReg <= timerReg + 22'h000001;
          end
        end
        ST_HOLD: begin
          // Wait for averaged result before moving on
          if (meanValid) begin
            if (!busPhaseReg && doBus) begin
              busPhaseReg <= 1'b1;
              stateReg    <= ST_CONV;
            end else begin
              chanReg  <= chanReg + 2'h1;
              stateReg <= ST_NEXT;
            end
          end else if (!sampleValidReg) begin
            stateReg <= ST_CONV;
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  // RULE11 read-only, zero after reset
  always @(posedge mclk) begin
    if (srst || softReset) begin
      shuntCh1Reg <= `TCM_RESULT_RESET;
      busCh1Reg   <= `TCM_RESULT_RESET;
      shuntCh2Reg <= `TCM_RESULT_RESET;
    end else if (meanValid && !setupWrite) begin
      // RULE7 RULE8 RULE9 RULE10 averaged left-justified word
      if (chanReg == 2'h0 && !busPhaseReg)
        shuntCh1Reg <= meanWord;
      if (chanReg == 2'h0 && busPhaseReg)
        busCh1Reg <= meanWord;
      if (chanReg == 2'h1 && !busPhaseReg)
        shuntCh2Reg <= meanWord;
    end
  end

  // ****************************************
  // Read port and outputs
  // ****************************************
  // RULE12 reads have no side effects
  always @(posedge mclk) begin
    if (srst) begin
      regRdata    <= 16'h0000;
      regRvalid   <= 1'b0;
      convChannel <= 2'h0;
      convIsBus   <= 1'b0;
      convBusy    <= 1'b0;
      setupWord   <= `TCM_SETUP_RESET;
    end else begin
      regRvalid   <= regRead;
      convChannel <= chanReg;
      convIsBus   <= busPhaseReg;
      convBusy    <= (stateReg == ST_CONV) || (stateReg == ST_HOLD);
      setupWord   <= setupReg;
      if (regRead) begin
        if (regAddr == `TCM_ADDR_SETUP)
          regRdata <= setupReg;
        else if (regAddr == `TCM_ADDR_SHUNT_CH1)
          regRdata <= shuntCh1Reg;
        else if (regAddr == `TCM_ADDR_BUS_CH1)
          regRdata <= busCh1Reg;
        else if (regAddr == `TCM_ADDR_SHUNT_CH2)
          regRdata <= shuntCh2Reg;
        else
          regRdata <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// *** tcm_monitor_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module tcm_monitor_props (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // Register port
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        regRvalid,
  // Converter port and setup copy
  input wire logic [1:0]  convChannel,
  input wire logic        convIsBus,
  input wire logic        convBusy,
  input wire logic        convDone,
  input wire logic [12:0] convData,
  input wire logic [15:0] setupWord
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Setup register write strobe
  wire setupWr = regWrite && (regAddr == 8'h00);
  read_answer_a: assert property (regRead |=> regRvalid)
    else $error("read not answered next cycle");
  stray_valid_a: assert property (!regRead |=> !regRvalid)
    else $error("read valid without a read");
  setup_default_a: assert property ($fell(srst) |-> setupWord == 16'h7127)
    else $error("setup not at default after reset");
  self_clear_a: assert property (!setupWord[15])
    else $error("reset bit did not clear");
  soft_reset_a: assert property (
    setupWr && regWdata[15] |-> ##[1:3] setupWord == 16'h7127)
    else $error("soft reset did not restore setup");
  setup_write_a: assert property (
    setupWr && !regWdata[15] ##1 !setupWr |=> setupWord == $past(regWdata, 2))
    else $error("setup write not stored");
  off_channel_a: assert property (
    (!setupWord[14])[*3] |-> !(convBusy && convChannel == 2'h0))
    else $error("disabled channel converted");
  power_down_a: assert property ((setupWord[1:0] == 2'h0)[*3] |-> !convBusy)
    else $error("converting in power-down");
  shunt_only_a: assert property (
    (setupWord[1:0] == 2'h1)[*3] |-> !(convBusy && convIsBus))
    else $error("bus measured in shunt-only mode");
  low_bits_a: assert property (
    regRvalid && $past(regAddr) >= 8'h01 && $past(regAddr) <= 8'h03 |-> regRdata[2:0] == 3'h0)
    else $error("result low bits not zero");
  unmapped_read_a: assert property (regRead && regAddr > 8'h03 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  // Main scenarios
  cover property (setupWr && regWdata[15]);
  cover property (convBusy && convIsBus);
  cover property (regRvalid && regRdata == 16'hC180);
endmodule
bind tcm_monitor_core tcm_monitor_props props (.mclk(mclk), .srst(srst), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
  .regRvalid(regRvalid), .convChannel(convChannel), .convIsBus(convIsBus),
  .convBusy(convBusy), .convDone(convDone), .convData(convData), .setupWord(setupWord));
`default_nettype wire

// *** tcm_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************
// Converter model
// ****************
module tcm_conv_model (
  // Clock
  input  wire logic        mclk,
  // Sequencer side
  input  wire logic [1:0]  convChannel,
  input  wire logic        convIsBus,
  input  wire logic        convBusy,
  // Sample out
  output wire logic        convDone,
  output wire logic [12:0] convData
);
  logic        doneReg = 1'b0;
  logic [12:0] dataReg = 13'h0000;
  // Single driver per output
  assign convDone = doneReg;
  assign convData = dataReg;
  // Fixed sample per channel and measurement kind; data toggles while idle
  always @(posedge mclk) begin
    if (convBusy) begin
      doneReg <= 1'b1;
      case ({convChannel, convIsBus})
        3'h0:    dataReg <= 13'h1830; // Minus 80 mV shunt
        3'h1:    dataReg <= 13'h0FFF; // Bus full scale
        default: dataReg <= 13'h0005;
      endcase
    end else begin
      doneReg <= 1'b0;
      dataReg <= ~dataReg;
    end
  end
endmodule
`default_nettype wire

// *** tcm_monitor_core_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// **********
// Testbench
// **********
module tcm_monitor_core_tb;
  logic        mclk = 1'b0;
  logic        srst = 1'b1;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  wire  [15:0] regRdata;
  wire         regRvalid;
  wire  [1:0]  convChannel;
  wire         convIsBus;
  wire         convBusy;
  wire         convDone;
  wire  [12:0] convData;
  wire  [15:0] setupWord;
  integer      miscompares = 0;
  integer      checked = 0;
  integer      i;
  always #2 mclk = ~mclk;
  tcm_monitor_core dut (.mclk(mclk), .srst(srst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .convChannel(convChannel), .convIsBus(convIsBus), .convBusy(convBusy),
    .convDone(convDone), .convData(convData), .setupWord(setupWord));
  tcm_conv_model conv (.mclk(mclk), .convChannel(convChannel), .convIsBus(convIsBus),
    .convBusy(convBusy), .convDone(convDone), .convData(convData));
  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Register write, one strobe cycle
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  // Register read with expected value
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    check({15'h0000, regRvalid}, 16'h0001);
    check(regRdata, exp);
  endtask
  // Bounded wait for the sequencer to go idle
  task wait_idle;
    integer n;
    repeat (4) @(posedge mclk);
    for (n = 0; n < 40000 && convBusy !== 1'b0; n = n + 1) @(posedge mclk);
    #1;
    check({15'h0000, convBusy}, 16'h0000);
  endtask
  task give_verdict;
    $display("Checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h00, 16'h7127);
    rd(8'h01, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h07, 16'h0000);
    wr(8'h01, 16'hFFFF);
    rd(8'h01, 16'h0000);
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h00, {1'b0, i[2:0], i[2:0], i[2:0], i[2:0], i[2:0]});
      rd(8'h00, {1'b0, i[2:0], i[2:0], i[2:0], i[2:0], i[2:0]});
    end
    wr(8'h00, 16'hFFFF);
    rd(8'h00, 16'h7127);
    check(setupWord, 16'h7127);
    wr(8'h00, 16'h4001);
    wait_idle();
    rd(8'h01, 16'hC180);
    rd(8'h02, 16'h0000);
    wr(8'h00, 16'h4002);
    wait_idle();
    rd(8'h02, 16'h7FF8);
    rd(8'h03, 16'h0000);
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares = miscompares + 1;
    give_verdict();
  end
endmodule
`default_nettype wire
